// ===== hw/hdf_pkg.sv
package hdf_pkg;
    localparam int unsigned hdf_depth = 512;
    localparam logic [9:0] hdf_cap_full = 10'h200;
    localparam logic [9:0] hdf_cap_small = 10'h0ff;
    // register offsets
    localparam logic [6:0] hdf_off_control = 7'h02;
    localparam logic [6:0] hdf_off_watermark = 7'h03;
    localparam logic [6:0] hdf_off_length = 7'h04;
    localparam logic [6:0] hdf_off_data = 7'h05;
    localparam logic [6:0] hdf_off_irq_status = 7'h06;
    localparam logic [6:0] hdf_off_irq_enable = 7'h07;
    // buffer_control_reg fields
    localparam int unsigned hdf_ctl_flush = 7;
    localparam int unsigned hdf_ctl_capsel = 6;
    localparam int unsigned hdf_ctl_high = 5;
    localparam int unsigned hdf_ctl_low = 4;
    localparam int unsigned hdf_ctl_wm_msb = 2;
    localparam int unsigned hdf_ctl_cnt_hi = 0;
    // interrupt_status_0 / interrupt_enable_0 fields
    localparam int unsigned hdf_irq_err = 1;
    localparam int unsigned hdf_irq_low = 2;
    localparam int unsigned hdf_irq_high = 3;
    // reset values
    localparam logic [8:0] hdf_wm_rst = 9'h000;
    localparam logic hdf_capsel_rst = 1'b0;
endpackage : hdf_pkg

// ===== hw/hdf_buffer.sv
// How it works
// - one 512 by 8 buffer shared by host and protocol engine
// - 255-entry mode; counts and watermark fit one byte there
// - capacity_select at 1 gives 255 entries, else 512
// - flush clears pointers and fill count, capacity from bit 6 of the same write
// - fill count rises per byte written, falls per byte read
// - fill count upper bits sit in buffer_control_reg
// - watermark is nine bits: msb at 02h bit 2, low byte at 03h
// - one watermark serves both high and low comparisons
// - high flag is capacity minus fill count not above watermark
// - low flag is fill count not above watermark
// - low flag rising with its enable raises irq
// - high flag rising with its enable raises irq
// - write into full buffer sets overflow error interrupt flag
`timescale 1ns/1ps
`default_nettype none
module hdf_buffer (
    input wire logic clk, // 250 MHz system clock
    input wire logic nrst, // async reset, active low
    input wire logic [6:0] reg_addr, // host register address
    input wire logic [7:0] reg_wdata, // host write data
    input wire logic reg_wr, // host write strobe
    input wire logic reg_rd, // host read strobe
    output logic [7:0] reg_rdata, // host read data, next cycle
    input wire logic eng_push, // engine writes a byte
    input wire logic [7:0] eng_push_data, // engine byte in
    input wire logic eng_pop, // engine reads a byte
    output logic [7:0] eng_pop_data, // engine byte out
    output logic eng_pop_valid, // eng_pop_data is fresh
    output logic irq // interrupt pin, active high
);
    typedef struct packed {
        logic [8:0] wr_ptr;
        logic [8:0] rd_ptr;
        logic [9:0] fill_count;
        logic capacity_select;
        logic [8:0] watermark_value;
        logic high_watermark_flag;
        logic low_watermark_flag;
        logic error_interrupt_flag;
        logic low_irq_flag;
        logic high_irq_flag;
        logic error_int_en;
        logic low_watermark_int_en;
        logic high_watermark_int_en;
        logic irq;
        logic [7:0] reg_rdata;
        logic [7:0] eng_pop_data;
        logic eng_pop_valid;
    } hdf_state_s;

    hdf_state_s st;
    hdf_state_s next_st;
    logic [7:0] mem [0:hdf_pkg::hdf_depth-1];

    logic [9:0] cap;
    logic full;
    logic empty;
    logic host_data_wr;
    logic host_data_rd;
    logic push;
    logic pop;
    logic push_ok;
    logic pop_ok;
    logic flush;
    logic [7:0] push_data;
    logic [7:0] pop_byte;
    logic [7:0] rd_mux;

    function automatic logic [8:0] hdf_ptr_inc(input logic [8:0] p,
            input logic [9:0] c);
        logic [9:0] nxt;
        nxt = {1'b0, p} + 10'h001;
        if (nxt >= c) begin
            hdf_ptr_inc = 9'h000;
        end else begin
            hdf_ptr_inc = nxt[8:0];
        end
    endfunction : hdf_ptr_inc

    function automatic logic hdf_high(input logic [9:0] c,
            input logic [9:0] n, input logic [8:0] w);
        // free space against watermark
        // a count above a shrunken capacity leaves no free space
        hdf_high = (n >= c) || ((c - n) <= {1'b0, w});
    endfunction : hdf_high

    function automatic logic [9:0] hdf_cap_of(input logic sel);
        hdf_cap_of = sel ? hdf_pkg::hdf_cap_small : hdf_pkg::hdf_cap_full;
    endfunction : hdf_cap_of

    assign cap = hdf_cap_of(st.capacity_select);
    assign full = (st.fill_count >= cap);
    assign empty = (st.fill_count == 10'h000);
    assign host_data_wr = reg_wr && (reg_addr == hdf_pkg::hdf_off_data);
    assign host_data_rd = reg_rd && (reg_addr == hdf_pkg::hdf_off_data);
    assign flush = reg_wr && (reg_addr == hdf_pkg::hdf_off_control)
                   && reg_wdata[hdf_pkg::hdf_ctl_flush];
    // host access takes the port when both collide
    assign push = host_data_wr || eng_push;
    assign push_data = host_data_wr ? reg_wdata : eng_push_data;
    assign pop = host_data_rd || eng_pop;
    // drop overflow bytes, ignore empty reads
    assign push_ok = push && !full && !flush;
    assign pop_ok = pop && !empty && !flush;
    assign pop_byte = mem[st.rd_ptr];

    always_ff @(posedge clk) begin
        if (push_ok) begin
            mem[st.wr_ptr] <= push_data;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            hdf_pkg::hdf_off_control: begin
                // upper fill count bits in control
                rd_mux[hdf_pkg::hdf_ctl_capsel] = st.capacity_select;
                rd_mux[hdf_pkg::hdf_ctl_high] = st.high_watermark_flag;
                rd_mux[hdf_pkg::hdf_ctl_low] = st.low_watermark_flag;
                rd_mux[hdf_pkg::hdf_ctl_wm_msb] = st.watermark_value[8];
                rd_mux[hdf_pkg::hdf_ctl_cnt_hi +: 2] = st.fill_count[9:8];
            end
            hdf_pkg::hdf_off_watermark: rd_mux = st.watermark_value[7:0];
            hdf_pkg::hdf_off_length: rd_mux = st.fill_count[7:0];
            hdf_pkg::hdf_off_data: rd_mux = empty ? 8'h00 : pop_byte;
            hdf_pkg::hdf_off_irq_status: begin
                rd_mux[hdf_pkg::hdf_irq_err] = st.error_interrupt_flag;
                rd_mux[hdf_pkg::hdf_irq_low] = st.low_irq_flag;
                rd_mux[hdf_pkg::hdf_irq_high] = st.high_irq_flag;
            end
            hdf_pkg::hdf_off_irq_enable: begin
                rd_mux[hdf_pkg::hdf_irq_err] = st.error_int_en;
                rd_mux[hdf_pkg::hdf_irq_low] = st.low_watermark_int_en;
                rd_mux[hdf_pkg::hdf_irq_high] = st.high_watermark_int_en;
            end
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.eng_pop_valid = 1'b0;
        if (reg_rd) begin
            next_st.reg_rdata = rd_mux;
        end
        // control and configuration writes
        if (reg_wr) begin
            case (reg_addr)
                hdf_pkg::hdf_off_control: begin
                    next_st.capacity_select =
                        reg_wdata[hdf_pkg::hdf_ctl_capsel];
                    next_st.watermark_value[8] =
                        reg_wdata[hdf_pkg::hdf_ctl_wm_msb];
                end
                hdf_pkg::hdf_off_watermark: begin
                    next_st.watermark_value[7:0] = reg_wdata;
                end
                hdf_pkg::hdf_off_irq_status: begin
                    // write 1 clears; events below win
                    if (reg_wdata[hdf_pkg::hdf_irq_err]) begin
                        next_st.error_interrupt_flag = 1'b0;
                    end
                    if (reg_wdata[hdf_pkg::hdf_irq_low]) begin
                        next_st.low_irq_flag = 1'b0;
                    end
                    if (reg_wdata[hdf_pkg::hdf_irq_high]) begin
                        next_st.high_irq_flag = 1'b0;
                    end
                end
                hdf_pkg::hdf_off_irq_enable: begin
                    next_st.error_int_en = reg_wdata[hdf_pkg::hdf_irq_err];
                    next_st.low_watermark_int_en =
                        reg_wdata[hdf_pkg::hdf_irq_low];
                    next_st.high_watermark_int_en =
                        reg_wdata[hdf_pkg::hdf_irq_high];
                end
                default: begin
                end
            endcase
        end
        // small mode keeps the watermark in one byte
        if (next_st.capacity_select) begin
            next_st.watermark_value[8] = 1'b0;
        end
        if (flush) begin
            next_st.wr_ptr = 9'h000;
            next_st.rd_ptr = 9'h000;
            next_st.fill_count = 10'h000;
        end else begin
            if (push_ok) begin
                next_st.wr_ptr = hdf_ptr_inc(st.wr_ptr, cap);
            end
            if (pop_ok) begin
                next_st.rd_ptr = hdf_ptr_inc(st.rd_ptr, cap);
            end
            if (push_ok && !pop_ok) begin
                next_st.fill_count = st.fill_count + 10'h001;
            end else if (pop_ok && !push_ok) begin
                next_st.fill_count = st.fill_count - 10'h001;
            end
        end
        if (eng_pop && !host_data_rd) begin
            next_st.eng_pop_data = pop_ok ? pop_byte : 8'h00;
            next_st.eng_pop_valid = pop_ok;
        end
        if (push && full && !flush) begin
            next_st.error_interrupt_flag = 1'b1;
        end
        next_st.high_watermark_flag = hdf_high(
            hdf_cap_of(next_st.capacity_select),
            next_st.fill_count, next_st.watermark_value);
        next_st.low_watermark_flag =
            (next_st.fill_count <= {1'b0, next_st.watermark_value});
        if (next_st.low_watermark_flag && !st.low_watermark_flag) begin
            next_st.low_irq_flag = 1'b1;
        end
        if (next_st.high_watermark_flag && !st.high_watermark_flag) begin
            next_st.high_irq_flag = 1'b1;
        end
        next_st.irq =
            (next_st.low_irq_flag && next_st.low_watermark_int_en) ||
            (next_st.high_irq_flag && next_st.high_watermark_int_en) ||
            (next_st.error_interrupt_flag && next_st.error_int_en);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.capacity_select <= hdf_pkg::hdf_capsel_rst;
            st.watermark_value <= hdf_pkg::hdf_wm_rst;
            st.low_watermark_flag <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.reg_rdata;
    assign eng_pop_data = st.eng_pop_data;
    assign eng_pop_valid = st.eng_pop_valid;
    assign irq = st.irq;
endmodule : hdf_buffer
`default_nettype wire

// ===== tb/hdf_buffer_props.sv
`timescale 1ns/1ps
`default_nettype none
module hdf_buffer_props (
    input wire logic clk, // clock
    input wire logic nrst, // reset
    input wire logic [6:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write
    input wire logic reg_rd, // read
    input wire logic [7:0] reg_rdata, // read data
    input wire logic eng_push, // push
    input wire logic [7:0] eng_push_data, // byte in
    input wire logic eng_pop, // pop
    input wire logic [7:0] eng_pop_data, // byte out
    input wire logic eng_pop_valid, // pop result
    input wire logic irq // interrupt
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    valid_cause_a: assert property (
        eng_pop_valid |-> $past(eng_pop)) else $error("valid without pop");
    rdata_hold_a: assert property (
        !$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(eng_push || eng_pop || reg_wr || reg_rd))
        else $error("irq rose without cause");
    unmapped_zero_a: assert property (
        reg_rd && (reg_addr > 7'h07 || reg_addr < 7'h02)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctl_reserved_a: assert property (
        reg_rd && reg_addr == 7'h02 |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("control reads flush or reserved");
    flush_zero_a: assert property (
        reg_wr && reg_addr == 7'h02 && reg_wdata[7] ##1 !eng_push && !reg_wr
        ##1 reg_rd && reg_addr == 7'h04 && !eng_push && !reg_wr
        |=> reg_rdata == 8'h00) else $error("count after flush");
    wm_rw_a: assert property (
        reg_wr && reg_addr == 7'h03 ##1 !reg_wr ##1 reg_rd && !reg_wr
        && reg_addr == 7'h03 |=> reg_rdata == $past(reg_wdata, 3))
        else $error("watermark readback");
    en_rw_a: assert property (
        reg_wr && reg_addr == 7'h07 ##1 !reg_wr ##1 reg_rd && !reg_wr
        && reg_addr == 7'h07 |=> reg_rdata == ($past(reg_wdata, 3) & 8'h0e))
        else $error("enable readback");
    irq_clear_a: assert property (
        reg_wr && reg_addr == 7'h06 && reg_wdata == 8'h0e && !eng_push
        && !eng_pop && !reg_rd |=> !irq) else $error("irq not cleared");
endmodule : hdf_buffer_props
bind hdf_buffer hdf_buffer_props u_props (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_push(eng_push),
    .eng_push_data(eng_push_data), .eng_pop(eng_pop),
    .eng_pop_data(eng_pop_data), .eng_pop_valid(eng_pop_valid), .irq(irq));
`default_nettype wire

// ===== tb/hdf_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module hdf_engine_model (
    input wire logic clk, // clock
    output logic eng_push, // push strobe
    output logic [7:0] eng_push_data, // byte in
    output logic eng_pop // pop strobe
);
    initial begin
        eng_push = 1'b0;
        eng_push_data = 8'h00;
        eng_pop = 1'b0;
    end
    task automatic push(input logic [7:0] d);
        @(posedge clk);
        #1;
        eng_push = 1'b1;
        eng_push_data = d;
        @(posedge clk);
        #1;
        eng_push = 1'b0;
        eng_push_data = ~d;
    endtask : push
    task automatic pop();
        @(posedge clk);
        #1;
        eng_pop = 1'b1;
        @(posedge clk);
        #1;
        eng_pop = 1'b0;
    endtask : pop
endmodule : hdf_engine_model
`default_nettype wire

// ===== tb/test_host_data_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module test_host_data_fifo;
    logic clk, nrst, reg_wr, reg_rd, eng_push, eng_pop, eng_pop_valid, irq;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, eng_push_data, eng_pop_data, r;
    logic [7:0] q_reg[$], q_pop[$], q_dat[$];
    logic rd_pend = 1'b0;
    int error_cnt, n_tests, i;
    hdf_buffer dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .eng_push(eng_push),
        .eng_push_data(eng_push_data), .eng_pop(eng_pop),
        .eng_pop_data(eng_pop_data), .eng_pop_valid(eng_pop_valid), .irq(irq));
    hdf_engine_model eng (.clk(clk), .eng_push(eng_push),
        .eng_push_data(eng_push_data), .eng_pop(eng_pop));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic cmp(input string nm, input logic [7:0] e,
            input logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp
    task automatic cmp_rdata(input logic [7:0] e);
        cmp("reg_rdata", e, reg_rdata);
    endtask : cmp_rdata
    task automatic cmp_pop(input logic [7:0] e);
        cmp("eng_pop_data", e, eng_pop_data);
    endtask : cmp_pop
    task automatic cmp_irq(input logic e);
        cmp("irq", {7'h00, e}, {7'h00, irq});
    endtask : cmp_irq
    always @(negedge clk) begin
        if (rd_pend) begin
            cmp_rdata(q_reg.size() ? q_reg.pop_front() : 8'hxx);
        end
        if (nrst === 1'b1 && eng_pop_valid !== 1'b0) begin
            cmp_pop(q_pop.size() ? q_pop.pop_front() : 8'hxx);
        end
        rd_pend = reg_rd;
    end
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask : acc
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        q_reg.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask : rd
    task automatic epush(input logic [7:0] d);
        q_dat.push_back(d);
        eng.push(d);
    endtask : epush
    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        nrst = 1'b0;
        {reg_wr, reg_rd} = 2'h0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        r = 8'($urandom(32'hd14263f9));
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        rd(7'h02, 8'h10);
        rd(7'h04, 8'h00);
        wr(7'h03, r);
        rd(7'h03, r);
        wr(7'h02, 8'h04);
        rd(7'h02, 8'h14);
        wr(7'h03, 8'h04);
        wr(7'h02, 8'h00);
        wr(7'h07, 8'h0e);
        rd(7'h07, 8'h0e);
        for (i = 0; i < 5; i++) begin
            r = 8'($urandom);
            q_dat.push_back(r);
            wr(7'h05, r);
        end
        rd(7'h04, 8'h05);
        rd(7'h02, 8'h00);
        for (i = 0; i < 5; i++) begin
            q_pop.push_back(q_dat.pop_front());
            eng.pop();
        end
        eng.pop();
        rd(7'h04, 8'h00);
        cmp_irq(1'b1);
        wr(7'h06, 8'h0e);
        cmp_irq(1'b0);
        for (i = 0; i < 3; i++) epush(8'($urandom));
        for (i = 0; i < 3; i++) rd(7'h05, q_dat.pop_front());
        wr(7'h02, 8'h40);
        for (i = 0; i < 255; i++) epush(8'($urandom));
        eng.push(8'h5a);
        rd(7'h04, 8'hff);
        rd(7'h02, 8'h60);
        rd(7'h06, 8'h0a);
        cmp_irq(1'b1);
        wr(7'h02, 8'hc0);
        q_dat.delete();
        rd(7'h04, 8'h00);
        rd(7'h02, 8'h50);
        wr(7'h02, 8'h00);
        for (i = 0; i < 300; i++) epush(8'($urandom));
        rd(7'h04, 8'h2c);
        rd(7'h02, 8'h01);
        for (i = 0; i < 300; i++) rd(7'h05, q_dat.pop_front());
        rd(7'h04, 8'h00);
        rd(7'h7f, 8'h00);
        repeat (3) @(posedge clk);
        cmp("pending", 8'h00, 8'(q_reg.size() + q_pop.size()));
        print_verdict();
    end
endmodule : test_host_data_fifo
`default_nettype wire
